// *** dv/dcp_pwm_test.sv ***
// Self-checking bench of the dual channel modulator top.
// Assumes one 25 MHz clock and an APB slave that answers within 16 cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module dcp_pwm_test
  import dcp_pkg::*;
;
  logic        clk     = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wave_a;
  logic        wave_b;
  logic [1:0]  own_lo;
  logic [1:0]  own_hi;
  logic [7:0]  rd;
  logic        err;
  int          n_mismatch = 0;
  int          compares   = 0;
  int          n;
  int          hi;

  always #20 clk = ~clk;

  dcp_pwm dut_u (
    .i_clk                 (clk),
    .i_rst_b               (rst_b),
    .i_psel                (psel),
    .i_penable             (penable),
    .i_pwrite              (pwrite),
    .i_paddr               (paddr),
    .i_pwdata              (pwdata),
    .i_pstrb               (pstrb),
    .o_prdata              (prdata),
    .o_pready              (pready),
    .o_pslverr             (pslverr),
    .o_wave_out_a          (wave_a),
    .o_wave_out_b          (wave_b),
    .o_port_group_low_own  (own_lo),
    .o_port_group_high_own (own_hi)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One APB transfer; ends one edge after release so calls never collide
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      give_verdict();
    end
    rd  = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task rchk(input logic [11:0] a, input logic [7:0] ex, input string nm);
    apb(1'b0, a, 8'h00);
    `CHK(nm, ex, rd)
  endtask

  // Cycles until the chosen wave shows lvl; bounded
  task wait_lvl(input bit ch, input logic lvl, input int lim);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((ch ? wave_b : wave_a) !== lvl && n < lim);
    if ((ch ? wave_b : wave_a) !== lvl)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  task hold(input bit ch, input logic lvl, input int cyc, input string nm);
    int bad;
    bad = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      if ((ch ? wave_b : wave_a) !== lvl)
        bad++;
    end
    `CHK(nm, 0, bad)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `CHK("wave a", 1'b0, wave_a)
    `CHK("wave b", 1'b0, wave_b)
    `CHK("own", 4'h0, {own_lo, own_hi})
    rchk(DCP_ADDR_CTRL_A, 8'h00, "ctrl a");
    rchk(DCP_ADDR_DIV1, 8'h00, "div1");
    rchk(DCP_ADDR_DUTY1, 8'h00, "duty1");
    rchk(DCP_ADDR_CTRL_B, 8'h00, "ctrl b");
    apb(1'b0, 12'h000, 8'h00);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 8'h00, rd)
    apb(1'b1, DCP_ADDR_DIV0 + 12'h001, 8'h55);
    `CHK("misaligned err", 1'b1, err)
    // Setup order as software must follow it
    apb(1'b1, DCP_ADDR_CTRL_A, 8'h02);
    pstrb <= 4'hE;
    apb(1'b1, DCP_ADDR_DIV0, 8'h07);
    pstrb <= 4'hF;
    apb(1'b1, DCP_ADDR_DIV0, 8'h01);
    apb(1'b1, DCP_ADDR_DUTY0, 8'h02);
    rchk(DCP_ADDR_DIV0, 8'h00, "div0 pending");
    rchk(DCP_ADDR_DUTY0, 8'h00, "duty0 pending");
    apb(1'b1, DCP_ADDR_CTRL_B, 8'h0C);
    `CHK("own hi", 2'b01, own_hi)
    `CHK("own lo", 2'b10, own_lo)
    apb(1'b1, DCP_ADDR_CTRL_B, 8'h0D);
    rchk(DCP_ADDR_DIV0, 8'h00, "div0 first");
    hold(1'b0, 1'b0, 480, "first period a");
    wait_lvl(1'b0, 1'b1, 80);
    rchk(DCP_ADDR_DIV0, 8'h01, "div0 moved");
    rchk(DCP_ADDR_DUTY0, 8'h02, "duty0 moved");
    // Every tick source; divider 1, duty 2
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, DCP_ADDR_CTRL_B, 8'h0C);
      apb(1'b1, DCP_ADDR_CTRL_A, {k[1:0], 6'h02});
      apb(1'b1, DCP_ADDR_CTRL_B, 8'h0D);
      wait_lvl(1'b0, 1'b1, 40);
      // First period starts off the tick grid; time the next one
      wait_lvl(1'b0, 1'b0, 20000);
      wait_lvl(1'b0, 1'b1, 20000);
      wait_lvl(1'b0, 1'b0, 20000);
      hi = n;
      `CHK("high time", 4 * (2 << k), hi)
      wait_lvl(1'b0, 1'b1, 20000);
      `CHK("period", 510 * (2 << k), hi + n)
    end
    // Disable mid-high: level must freeze
    apb(1'b1, DCP_ADDR_CTRL_B, 8'h0C);
    hold(1'b0, 1'b1, 100, "frozen a");
    rchk(DCP_ADDR_DIV0, 8'h01, "div0 kept");
    rchk(DCP_ADDR_DUTY0, 8'h02, "duty0 kept");
    // Second channel at full duty
    apb(1'b1, DCP_ADDR_CTRL_A, 8'h02);
    apb(1'b1, DCP_ADDR_DUTY1, 8'hFF);
    apb(1'b1, DCP_ADDR_CTRL_B, 8'h0E);
    hold(1'b1, 1'b0, 480, "first period b");
    wait_lvl(1'b1, 1'b1, 80);
    hold(1'b1, 1'b1, 600, "full duty");
    rchk(DCP_ADDR_DUTY1, 8'hFF, "duty1 moved");
    `CHK("wave a idle", 1'b1, wave_a)
    apb(1'b1, DCP_ADDR_CTRL_B, 8'h0C);
    hold(1'b1, 1'b1, 100, "frozen b");
    apb(1'b1, DCP_ADDR_CTRL_A, 8'h01);
    `CHK("own lo swap", 2'b01, own_lo)
    `CHK("own hi swap", 2'b10, own_hi)
    apb(1'b1, DCP_ADDR_CTRL_B, 8'h00);
    `CHK("own off", 4'h0, {own_lo, own_hi})
    apb(1'b1, DCP_ADDR_CTRL_A, 8'hFF);
    rchk(DCP_ADDR_CTRL_A, 8'hC3, "ctrl a mask");
    apb(1'b1, DCP_ADDR_CTRL_B, 8'hF0);
    rchk(DCP_ADDR_CTRL_B, 8'h00, "ctrl b mask");
    give_verdict();
  end
endmodule

// *** rtl/dcp_chan.sv ***
// One modulator channel: prelatches, active latches, step and period counters.
// Assumes a one-cycle tick enable from the shared tick source divider.
`timescale 1ns/1ps
module dcp_chan
  import dcp_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // Control
  input  wire logic             i_tick,
  input  wire logic             i_en,
  // Register writes
  input  wire logic             i_wr_div,
  input  wire logic             i_wr_duty,
  input  wire logic [WIDTH-1:0] i_wdata,
  // State
  output logic      [WIDTH-1:0] o_div,
  output logic      [WIDTH-1:0] o_duty,
  output logic                  o_wave
);

  logic [WIDTH-1:0] div_pl_q,  div_pl_d;
  logic [WIDTH-1:0] duty_pl_q, duty_pl_d;
  logic [WIDTH-1:0] div_l_q,   div_l_d;
  logic [WIDTH-1:0] duty_l_q,  duty_l_d;
  logic [WIDTH-1:0] pcnt_q,    pcnt_d;
  logic [WIDTH-1:0] step_q,    step_d;
  logic             wave_q,    wave_d;
  logic             en_q;
  logic             start;
  logic             adv;
  logic             pend;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    start     = i_en & ~en_q;
    adv       = i_en & ~start & i_tick & (pcnt_q == '0);
    pend      = adv & (step_q == WIDTH'(DCP_STEP_LAST));
    div_pl_d  = div_pl_q;
    duty_pl_d = duty_pl_q;
    div_l_d   = div_l_q;
    duty_l_d  = duty_l_q;
    pcnt_d    = pcnt_q;
    step_d    = step_q;
    wave_d    = wave_q;
    if (i_wr_div)
    begin
      div_pl_d = i_wdata;
    end
    if (i_wr_duty)
    begin
      duty_pl_d = i_wdata;
    end
    if (start)
    begin
      // First period after enable runs on the old latches
      pcnt_d = div_l_q;
      step_d = '0;
    end
    else if (pend)
    begin
      div_l_d  = div_pl_q;
      duty_l_d = duty_pl_q;
      pcnt_d   = div_pl_q;
      step_d   = '0;
    end
    else if (adv)
    begin
      pcnt_d = div_l_q;
      step_d = step_q + WIDTH'(1);
    end
    else if (i_en & i_tick)
    begin
      pcnt_d = pcnt_q - WIDTH'(1);
    end
    // Disabled: level frozen, counters and latches kept
    if (i_en)
    begin
      wave_d = (step_d < duty_l_d);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      div_pl_q  <= DCP_RST_DIV;
      duty_pl_q <= DCP_RST_DUTY;
      div_l_q   <= DCP_RST_DIV;
      duty_l_q  <= DCP_RST_DUTY;
      pcnt_q    <= '0;
      step_q    <= '0;
      wave_q    <= 1'b0;
      en_q      <= 1'b0;
    end
    else
    begin
      div_pl_q  <= div_pl_d;
      duty_pl_q <= duty_pl_d;
      div_l_q   <= div_l_d;
      duty_l_q  <= duty_l_d;
      pcnt_q    <= pcnt_d;
      step_q    <= step_d;
      wave_q    <= wave_d;
      en_q      <= i_en;
    end
  end

  assign o_div  = div_l_q;
  assign o_duty = duty_l_q;
  assign o_wave = wave_q;

  ////////////////////////////////////////////////////////////////////////////
  chk_freeze_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_en |=> $stable(o_wave))
    else $error("output moved while disabled");

  chk_level_duty: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $past(i_en) |-> o_wave == (step_q < duty_l_q))
    else $error("output level disagrees with step and duty");

  chk_latch_transfer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    pend |=> (div_l_q == $past(div_pl_q)) && (pcnt_q == $past(div_pl_q)))
    else $error("divider prelatch not transferred at period start");

  chk_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !pend |=> $stable(div_l_q) && $stable(duty_l_q))
    else $error("latch changed outside a period boundary");

  chk_step_range: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    step_q <= WIDTH'(DCP_STEP_LAST))
    else $error("step counter passed 254");

  chk_duty_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $past(i_en) && duty_l_q == '0 |-> !o_wave)
    else $error("zero duty drove high");

endmodule

// *** rtl/dcp_pkg.sv ***
// Shared constants of the dual channel pulse width modulator.
// Assumes APB with 32-bit data; register index times four is the byte address.
package dcp_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [11:0] DCP_IDX_CTRL_A = 12'h370;
  localparam logic [11:0] DCP_IDX_DIV0   = 12'h372;
  localparam logic [11:0] DCP_IDX_DUTY0  = 12'h373;
  localparam logic [11:0] DCP_IDX_DIV1   = 12'h374;
  localparam logic [11:0] DCP_IDX_DUTY1  = 12'h375;
  localparam logic [11:0] DCP_IDX_CTRL_B = 12'h376;

  localparam int          DCP_AW         = 12;

  // Byte addresses on the bus
  localparam logic [11:0] DCP_ADDR_CTRL_A = 12'(DCP_IDX_CTRL_A * 4);
  localparam logic [11:0] DCP_ADDR_DIV0   = 12'(DCP_IDX_DIV0 * 4);
  localparam logic [11:0] DCP_ADDR_DUTY0  = 12'(DCP_IDX_DUTY0 * 4);
  localparam logic [11:0] DCP_ADDR_DIV1   = 12'(DCP_IDX_DIV1 * 4);
  localparam logic [11:0] DCP_ADDR_DUTY1  = 12'(DCP_IDX_DUTY1 * 4);
  localparam logic [11:0] DCP_ADDR_CTRL_B = 12'(DCP_IDX_CTRL_B * 4);

  // Field positions of output_control_a
  localparam int DCP_A_SEL0    = 0;
  localparam int DCP_A_SEL1    = 1;
  localparam int DCP_A_TICK_LO = 6;
  localparam int DCP_A_TICK_HI = 7;

  // Field positions of output_control_b
  localparam int DCP_B_EN0     = 0;
  localparam int DCP_B_EN1     = 1;
  localparam int DCP_B_PORT0   = 2;
  localparam int DCP_B_PORT1   = 3;

  // Implemented bits; the rest read as zero
  localparam logic [7:0] DCP_MASK_CTRL_A = 8'hC3;
  localparam logic [7:0] DCP_MASK_CTRL_B = 8'h0F;

  // Reset values
  localparam logic [7:0] DCP_RST_CTRL = 8'h00;
  localparam logic [7:0] DCP_RST_DIV  = 8'h00;
  localparam logic [7:0] DCP_RST_DUTY = 8'h00;

  // Last step of a 255-step period
  localparam logic [7:0] DCP_STEP_LAST = 8'hFE;

  // Tick source divider width (divide by up to 16)
  localparam int DCP_TDIV_W = 4;

endpackage

// *** rtl/dcp_pwm.sv ***
// Overview of operation
// - Two independent channels, each with 8-bit duty resolution.
// - Tick source is base clock divided by 2, 4, 8 or 16, bits 7-6.
// - Both channel prescalers run from one shared tick source.
// - Period is 255 times (divider plus one) ticks.
// - High time is (divider plus one) times duty ticks.
// - Divider writes go to a hidden prelatch, loaded at next period start.
// - Divider reads return the active latch, not the pending prelatch.
// - Duty writes go to a hidden prelatch, loaded at next period start.
// - Duty reads return the active duty latch.
// - After enabling, the first period still uses the old settings.
// - Clearing enable freezes the output at its present level.
// - Divider and duty keep their values while disabled.
// - Outputs are low right after reset.
// - Control b bits 0 and 1 enable channel 0 and 1 output.
// - Control b bits 2 and 3 hand the chosen pin to the modulator.
// - Control a bits 0 and 1 pick the pin group per channel.
// - Switch 0 leaves an ordinary port; switch 1 carries pulses or holds.
//
// Top of the modulator: APB register slave, tick divider and pin routing.
// Assumes an APB master on i_clk and port logic that honours the pin owns.
`timescale 1ns/1ps
module dcp_pwm
  import dcp_pkg::*;
#(
  parameter int NCH   = 2,
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // APB slave
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [DCP_AW-1:0] i_paddr,
  input  wire logic [31:0]      i_pwdata,
  input  wire logic [3:0]       i_pstrb,
  output logic      [31:0]      o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  // Waveforms
  output logic                  o_wave_out_a,
  output logic                  o_wave_out_b,
  // Pin ownership per channel
  output logic      [NCH-1:0]   o_port_group_low_own,
  output logic      [NCH-1:0]   o_port_group_high_own
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0]          ctrl_a_q, ctrl_a_d;
  logic [7:0]          ctrl_b_q, ctrl_b_d;
  logic [31:0]         prdata_q, prdata_d;
  logic                setup;
  logic                access;
  logic                hit;
  logic                wr_ok;
  logic                sel_ctrl_a;
  logic                sel_ctrl_b;
  logic [NCH-1:0]      sel_div;
  logic [NCH-1:0]      sel_duty;
  logic [NCH-1:0]      wr_div;
  logic [NCH-1:0]      wr_duty;
  logic [NCH-1:0]      ch_en;
  logic [NCH-1:0]      ch_wave;
  logic [WIDTH-1:0]    ch_div  [NCH];
  logic [WIDTH-1:0]    ch_duty [NCH];
  logic [11:0]         div_addr  [NCH];
  logic [11:0]         duty_addr [NCH];

  assign div_addr[0]  = DCP_ADDR_DIV0;
  assign div_addr[1]  = DCP_ADDR_DIV1;
  assign duty_addr[0] = DCP_ADDR_DUTY0;
  assign duty_addr[1] = DCP_ADDR_DUTY1;

  // Decode
  always_comb
  begin
    setup      = i_psel & ~i_penable;
    access     = i_psel & i_penable;
    sel_ctrl_a = (i_paddr == DCP_ADDR_CTRL_A);
    sel_ctrl_b = (i_paddr == DCP_ADDR_CTRL_B);
    for (int c = 0; c < NCH; c++)
    begin
      sel_div[c]  = (i_paddr == div_addr[c]);
      sel_duty[c] = (i_paddr == duty_addr[c]);
    end
    hit = sel_ctrl_a | sel_ctrl_b | (|sel_div) | (|sel_duty);
    // Data sits in the low byte; a write without that lane stores nothing
    wr_ok = access & i_pwrite & hit & i_pstrb[0];
  end

  assign wr_div  = sel_div  & {NCH{wr_ok}};
  assign wr_duty = sel_duty & {NCH{wr_ok}};

  // Control registers
  always_comb
  begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    if (wr_ok & sel_ctrl_a)
    begin
      ctrl_a_d = i_pwdata[7:0] & DCP_MASK_CTRL_A;
    end
    if (wr_ok & sel_ctrl_b)
    begin
      ctrl_b_d = i_pwdata[7:0] & DCP_MASK_CTRL_B;
    end
  end

  // Read data captured in setup so it stands through the access phase
  always_comb
  begin
    prdata_d = prdata_q;
    if (setup & ~i_pwrite)
    begin
      prdata_d = 32'h0000_0000;
      if (sel_ctrl_a)
      begin
        prdata_d[7:0] = ctrl_a_q;
      end
      if (sel_ctrl_b)
      begin
        prdata_d[7:0] = ctrl_b_q;
      end
      for (int c = 0; c < NCH; c++)
      begin
        if (sel_div[c])
        begin
          prdata_d[WIDTH-1:0] = ch_div[c];
        end
        if (sel_duty[c])
        begin
          prdata_d[WIDTH-1:0] = ch_duty[c];
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      ctrl_a_q <= DCP_RST_CTRL;
      ctrl_b_q <= DCP_RST_CTRL;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      prdata_q <= prdata_d;
    end
  end

  // Zero wait states; unmapped or misaligned addresses answer with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~hit;
  assign o_prdata  = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Shared tick source

  logic [DCP_TDIV_W-1:0] tdiv_q, tdiv_d;
  logic [DCP_TDIV_W-1:0] tmask;
  logic                  tick;

  always_comb
  begin
    // Select 0..3 gives masks 1, 3, 7, 15: divide by 2, 4, 8, 16
    case (ctrl_a_q[DCP_A_TICK_HI:DCP_A_TICK_LO])
      2'h0:    tmask = 4'h1;
      2'h1:    tmask = 4'h3;
      2'h2:    tmask = 4'h7;
      2'h3:    tmask = 4'hF;
      default: tmask = 4'h1;
    endcase
    tdiv_d = tdiv_q + DCP_TDIV_W'(1);
    // Free running; changing the select mid-run may shorten one tick
    tick   = ((tdiv_q & tmask) == tmask);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      tdiv_q <= '0;
    end
    else
    begin
      tdiv_q <= tdiv_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  assign ch_en[0] = ctrl_b_q[DCP_B_EN0];
  assign ch_en[1] = ctrl_b_q[DCP_B_EN1];

  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
      dcp_chan #(
        .WIDTH (WIDTH)
      ) u_chan (
        .i_clk     (i_clk),
        .i_rst_b   (i_rst_b),
        .i_tick    (tick),
        .i_en      (ch_en[g]),
        .i_wr_div  (wr_div[g]),
        .i_wr_duty (wr_duty[g]),
        .i_wdata   (i_pwdata[WIDTH-1:0]),
        .o_div     (ch_div[g]),
        .o_duty    (ch_duty[g]),
        .o_wave    (ch_wave[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing

  logic [NCH-1:0] port_sw;
  logic [NCH-1:0] grp_sel;

  assign port_sw[0] = ctrl_b_q[DCP_B_PORT0];
  assign port_sw[1] = ctrl_b_q[DCP_B_PORT1];
  assign grp_sel[0] = ctrl_a_q[DCP_A_SEL0];
  assign grp_sel[1] = ctrl_a_q[DCP_A_SEL1];

  // Switch low leaves the pin to the port; held level shows while disabled
  assign o_port_group_high_own = port_sw & ~grp_sel;
  assign o_port_group_low_own  = port_sw &  grp_sel;
  assign o_wave_out_a          = ch_wave[0];
  assign o_wave_out_b          = ch_wave[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic ctrl_a_wr;

  // A select write mid-count shortens one tick, so those attempts are dropped
  assign ctrl_a_wr = wr_ok & sel_ctrl_a;

  chk_tick_div2: assert property (@(posedge i_clk)
    disable iff (!i_rst_b || ctrl_a_wr)
    tick && ctrl_a_q[7:6] == 2'h0 |=> !tick ##1 tick)
    else $error("divide by two tick spacing wrong");

  chk_tick_div4: assert property (@(posedge i_clk)
    disable iff (!i_rst_b || ctrl_a_wr)
    tick && ctrl_a_q[7:6] == 2'h1 |=> !tick [*3] ##1 tick)
    else $error("divide by four tick spacing wrong");

  chk_tick_div8: assert property (@(posedge i_clk)
    disable iff (!i_rst_b || ctrl_a_wr)
    tick && ctrl_a_q[7:6] == 2'h2 |=> !tick [*7] ##1 tick)
    else $error("divide by eight tick spacing wrong");

  chk_tick_div16: assert property (@(posedge i_clk)
    disable iff (!i_rst_b || ctrl_a_wr)
    tick && ctrl_a_q[7:6] == 2'h3 && $stable(ctrl_a_q) |=> !tick [*8])
    else $error("divide by sixteen tick too early");

  chk_reset_low: assert property (@(posedge i_clk)
    !i_rst_b |=> !o_wave_out_a && !o_wave_out_b)
    else $error("output not low after reset");

  chk_div_hidden: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_div[0] && !(ch_en[0] && tick) |=> ch_div[0] == $past(ch_div[0]))
    else $error("divider write visible before period start");

  chk_hold_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !ch_en[1] && !wr_duty[1] |=> $stable(ch_duty[1]) && $stable(ch_div[1]))
    else $error("settings changed while disabled");

  chk_pin_owner: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !(o_port_group_low_own[0] && o_port_group_high_own[0]))
    else $error("one channel owns both pin groups");

  chk_enable_bit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_ok && sel_ctrl_b |=> ch_en[0] == $past(i_pwdata[0]))
    else $error("enable bit not taken from write");

  chk_bad_addr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    access && !hit |-> o_pslverr && o_pready)
    else $error("unmapped access not refused");

  chk_tick_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_a_wr |=> ctrl_a_q[7:6] == $past(i_pwdata[7:6]))
    else $error("tick select not taken from write");

  chk_group_bits: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ctrl_a_wr |=> grp_sel == $past(i_pwdata[1:0]))
    else $error("group select not taken from write");

  chk_switch_bits: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_ok && sel_ctrl_b |=> port_sw == $past(i_pwdata[3:2]))
    else $error("pin switch not taken from write");

  chk_enable_bit1: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_ok && sel_ctrl_b |=> ch_en[1] == $past(i_pwdata[1]))
    else $error("second enable bit not taken from write");

  chk_ctrl_masks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ctrl_a_q & ~DCP_MASK_CTRL_A) == 8'h00 && (ctrl_b_q & ~DCP_MASK_CTRL_B) == 8'h00)
    else $error("unimplemented control bit set");

  chk_div_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    setup && !i_pwrite && sel_div[0] |=> o_prdata[7:0] == $past(ch_div[0]))
    else $error("divider read not from active latch");

  chk_duty_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    setup && !i_pwrite && sel_duty[1] |=> o_prdata[7:0] == $past(ch_duty[1]))
    else $error("duty read not from active latch");

  chk_rdata_upper: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");

  chk_freeze_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !ch_en[0] |=> $stable(o_wave_out_a))
    else $error("first output moved while disabled");

  chk_freeze_b: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !ch_en[1] |=> $stable(o_wave_out_b))
    else $error("second output moved while disabled");

  chk_own_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !port_sw[1] |-> !o_port_group_low_own[1] && !o_port_group_high_own[1])
    else $error("pin owned with switch off");

  chk_err_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !access |-> !o_pslverr)
    else $error("error outside access phase");

  chk_reset_regs: assert property (@(posedge i_clk)
    !i_rst_b |=> ctrl_a_q == DCP_RST_CTRL && ctrl_b_q == DCP_RST_CTRL)
    else $error("control not cleared by reset");

endmodule
